// >>> hw/ttp_timer_top.v
// Triple timer: shared 21-bit prescaler, three channels, register port and outputs.
`timescale 1ns/100ps
`include "ttp_defs.vh"
module ttp_timer_top (
    // Clock and reset
    input  wire                clk_in,
    input  wire                rst_b_in,
    input  wire                sw_reset_in,
    // Core power state
    input  wire                core_stop_in,
    // Register port
    input  wire [`TTP_AW-1:0]  reg_addr_in,
    input  wire                reg_wr_in,
    input  wire                reg_rd_in,
    input  wire [`TTP_DW-1:0]  reg_wdata_in,
    output wire [`TTP_DW-1:0]  reg_rdata_out,
    // Interrupt service acknowledges
    input  wire [2:0]          ovf_ack_in,
    input  wire [2:0]          cmp_ack_in,
    // Interrupt, wake and DMA outputs
    output wire [2:0]          ovf_irq_out,
    output wire [2:0]          cmp_irq_out,
    output wire                wake_out,
    output wire [2:0]          dma_trig_out
);
    reg  [`TTP_DW-1:0]   rdata_ff;
    reg  [2:0]           ovf_irq_ff;
    reg  [2:0]           cmp_irq_ff;
    reg                  wake_ff;
    reg  [2:0]           dma_ff;
    reg  [`TTP_DW-1:0]   pload_ff;
    reg  [`TTP_PW-1:0]   pre_ff;
    reg                  div_ff;
    reg  [`TTP_DW-1:0]   nxt_rdata;
    wire [3*`TTP_DW-1:0] ctl_bus;
    wire [3*`TTP_CW-1:0] cnt_bus;
    wire [3*`TTP_CW-1:0] cmp_bus;
    wire [2:0]           run;
    wire [2:0]           pre_sel;
    wire [2:0]           ovf;
    wire [2:0]           cmpf;
    wire [2:0]           evt;
    wire [2:0]           tick;
    wire                 pre_run;
    wire                 src_ok;
    wire                 pre_in_tick;
    wire                 pre_out_tick;
    wire [1:0]           sel_idx;
    wire [1:0]           sel_ofs;

    // True when the address hits word ofs of timer idx.
    function hit;
        input [`TTP_AW-1:0] addr;
        input integer       idx;
        input [1:0]         ofs;
        begin
            // Only the low two bits of the channel number select a timer.
            hit = (addr[3:2] == idx[1:0]) && (addr[1:0] == ofs);
        end
    endfunction

    assign sel_idx = reg_addr_in[3:2];
    assign sel_ofs = reg_addr_in[1:0];

    // The prescaler only burns power when some running timer listens to it.
    assign pre_run      = |(run & pre_sel);
    assign src_ok       = (pload_ff[`TTP_PSRC_HI:`TTP_PSRC_LO] == `TTP_PSRC_CLK_DIV2);
    assign pre_in_tick  = div_ff && src_ok && pre_run && !core_stop_in;
    assign pre_out_tick = pre_in_tick && (pre_ff == `TTP_RST_PRE);

    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            div_ff   <= 1'b0;
            pre_ff   <= `TTP_RST_PRE;
            pload_ff <= `TTP_RST_WORD;
        end else begin
            if (reg_wr_in && (reg_addr_in == `TTP_ADDR_PLOAD)) begin
                pload_ff <= reg_wdata_in & `TTP_PLOAD_WMASK;
            end
            if (!pre_run || core_stop_in) begin
                div_ff <= 1'b0;
            end else begin
                div_ff <= ~div_ff;
            end
            if (!pre_run) begin
                pre_ff <= pload_ff[`TTP_PW-1:0];
            end else if (pre_in_tick) begin
                if (pre_ff == `TTP_RST_PRE) begin
                    pre_ff <= pload_ff[`TTP_PW-1:0];
                end else begin
                    pre_ff <= pre_ff - 21'h000001;
                end
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : chan
            // Wait state leaves ticks running; stop state removes them.
            assign tick[g] = !core_stop_in && (pre_sel[g] ? pre_out_tick : 1'b1);
            ttp_timer_chan u_chan (
                .clk_in      (clk_in),
                .rst_b_in    (rst_b_in),
                .sw_reset_in (sw_reset_in),
                .tick_in     (tick[g]),
                .ctl_wr_in   (reg_wr_in && hit(reg_addr_in, g, `TTP_OFS_CTL)),
                .load_wr_in  (reg_wr_in && hit(reg_addr_in, g, `TTP_OFS_LOAD)),
                .cmp_wr_in   (reg_wr_in && hit(reg_addr_in, g, `TTP_OFS_COMPARE)),
                .wdata_in    (reg_wdata_in),
                .ovf_ack_in  (ovf_ack_in[g]),
                .cmp_ack_in  (cmp_ack_in[g]),
                .ctl_out     (ctl_bus[g*`TTP_DW +: `TTP_DW]),
                .count_out   (cnt_bus[g*`TTP_CW +: `TTP_CW]),
                .compare_out (cmp_bus[g*`TTP_CW +: `TTP_CW]),
                .run_out     (run[g]),
                .pre_sel_out (pre_sel[g]),
                .ovf_out     (ovf[g]),
                .cmp_out     (cmpf[g]),
                .event_out   (evt[g])
            );
        end
    endgenerate

    // Channel load registers are write-only and read back as zero; the prescaler load register reads back.
    always @* begin
        nxt_rdata = `TTP_RST_WORD;
        if (sel_idx == `TTP_IDX_PRE) begin
            if (reg_addr_in == `TTP_ADDR_PLOAD) begin
                nxt_rdata = pload_ff;
            end else if (reg_addr_in == `TTP_ADDR_PCOUNT) begin
                nxt_rdata = {{(`TTP_DW-`TTP_PW){1'b0}}, pre_ff};
            end
        end else begin
            case (sel_ofs)
                `TTP_OFS_CTL: begin
                    nxt_rdata = ctl_bus[sel_idx*`TTP_DW +: `TTP_DW];
                end
                `TTP_OFS_COUNT: begin
                    nxt_rdata = cnt_bus[sel_idx*`TTP_CW +: `TTP_CW];
                end
                `TTP_OFS_COMPARE: begin
                    nxt_rdata = cmp_bus[sel_idx*`TTP_CW +: `TTP_CW];
                end
                default: begin
                    nxt_rdata = `TTP_RST_WORD;
                end
            endcase
        end
    end

    integer i;
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_ff   <= `TTP_RST_WORD;
            ovf_irq_ff <= 3'h0;
            cmp_irq_ff <= 3'h0;
            wake_ff    <= 1'b0;
            dma_ff     <= 3'h0;
        end else begin
            if (reg_rd_in) begin
                rdata_ff <= nxt_rdata;
            end
            for (i = 0; i < 3; i = i + 1) begin
                ovf_irq_ff[i] <= ovf[i] && ctl_bus[i*`TTP_DW + `TTP_BIT_OVF_IE];
                cmp_irq_ff[i] <= cmpf[i] && ctl_bus[i*`TTP_DW + `TTP_BIT_CMP_IE]
                                 && !(ovf[i] && ctl_bus[i*`TTP_DW + `TTP_BIT_OVF_IE]);
            end
            wake_ff <= |(ovf_irq_ff | cmp_irq_ff);
            dma_ff  <= evt;
        end
    end

    assign reg_rdata_out = rdata_ff;
    assign ovf_irq_out   = ovf_irq_ff;
    assign cmp_irq_out   = cmp_irq_ff;
    assign wake_out      = wake_ff;
    assign dma_trig_out  = dma_ff;
endmodule

// >>> hw/ttp_defs.vh
// Constants for the triple timer with shared prescaler.
`ifndef TTP_DEFS_VH
`define TTP_DEFS_VH
`define TTP_DW            24
`define TTP_CW            24
`define TTP_PW            21
`define TTP_AW            4
`define TTP_OFS_CTL       2'h0
`define TTP_OFS_COUNT     2'h1
`define TTP_OFS_LOAD      2'h2
`define TTP_OFS_COMPARE   2'h3
`define TTP_IDX_PRE       2'h3
`define TTP_ADDR_PLOAD    4'hC
`define TTP_ADDR_PCOUNT   4'hD
`define TTP_BIT_EN        0
`define TTP_BIT_OVF_IE    1
`define TTP_BIT_CMP_IE    2
`define TTP_MODE_LO       4
`define TTP_MODE_HI       7
`define TTP_BIT_RELOAD    9
`define TTP_BIT_PRE_SEL   15
`define TTP_BIT_OVF_FLAG  20
`define TTP_BIT_CMP_FLAG  21
`define TTP_CTL_WMASK     24'h0082F7
`define TTP_MODE_COMPARE  4'h0
`define TTP_RST_CTL       24'h000000
`define TTP_RST_WORD      24'h000000
`define TTP_RST_PRE       21'h000000
`define TTP_PSRC_LO       21
`define TTP_PSRC_HI       22
`define TTP_PSRC_CLK_DIV2 2'h0
`define TTP_PLOAD_WMASK   24'h7FFFFF
`endif

// >>> hw/ttp_timer_chan.v
// One 24-bit timer channel with its control, count, load and compare registers.
`timescale 1ns/100ps
`include "ttp_defs.vh"
module ttp_timer_chan (
    // Clock and reset
    input  wire                clk_in,
    input  wire                rst_b_in,
    input  wire                sw_reset_in,
    // Timer clock enable
    input  wire                tick_in,
    // Register writes
    input  wire                ctl_wr_in,
    input  wire                load_wr_in,
    input  wire                cmp_wr_in,
    input  wire [`TTP_DW-1:0]  wdata_in,
    // Interrupt service
    input  wire                ovf_ack_in,
    input  wire                cmp_ack_in,
    // State
    output wire [`TTP_DW-1:0]  ctl_out,
    output wire [`TTP_CW-1:0]  count_out,
    output wire [`TTP_CW-1:0]  compare_out,
    output wire                run_out,
    output wire                pre_sel_out,
    output wire                ovf_out,
    output wire                cmp_out,
    output wire                event_out
);
    reg  [`TTP_DW-1:0] ctl_ff;
    reg  [`TTP_CW-1:0] cnt_ff;
    reg  [`TTP_CW-1:0] load_ff;
    reg  [`TTP_CW-1:0] cmpv_ff;
    reg                ovf_ff;
    reg                cmpf_ff;
    reg                first_ff;
    reg                reload_ff;
    reg                evt_ff;
    reg  [`TTP_DW-1:0] nxt_ctl;
    reg  [`TTP_CW-1:0] nxt_cnt;
    reg                nxt_ovf;
    reg                nxt_cmpf;
    reg                nxt_first;
    reg                nxt_reload;
    reg                hit_ovf;
    reg                hit_cmp;
    reg  [`TTP_CW:0]   sum;
    wire               en;
    wire               run;

    assign en  = ctl_ff[`TTP_BIT_EN];
    // Reserved mode codes leave the counter frozen.
    assign run = en && (ctl_ff[`TTP_MODE_HI:`TTP_MODE_LO] == `TTP_MODE_COMPARE);

    always @* begin
        nxt_ctl    = ctl_ff;
        nxt_cnt    = cnt_ff;
        nxt_first  = first_ff;
        nxt_reload = reload_ff;
        hit_ovf    = 1'b0;
        hit_cmp    = 1'b0;
        sum        = {1'b0, cnt_ff} + 25'h0000001;
        if (run && tick_in) begin
            if (first_ff || reload_ff) begin
                nxt_cnt    = load_ff;
                nxt_first  = 1'b0;
                nxt_reload = 1'b0;
            end else begin
                nxt_cnt = sum[`TTP_CW-1:0];
                hit_ovf = sum[`TTP_CW];
            end
            if (nxt_cnt == cmpv_ff) begin
                hit_cmp    = 1'b1;
                nxt_reload = ctl_ff[`TTP_BIT_RELOAD];
            end
        end
        if (ctl_wr_in) begin
            nxt_ctl = wdata_in & `TTP_CTL_WMASK;
            if (wdata_in[`TTP_BIT_EN] && !en) begin
                nxt_cnt    = `TTP_RST_WORD;
                nxt_first  = 1'b1;
                nxt_reload = 1'b0;
            end
        end
        // Set beats clear so an event landing on the clear is kept.
        nxt_ovf  = hit_ovf | (ovf_ff & ~((ctl_wr_in & wdata_in[`TTP_BIT_OVF_FLAG]) | ovf_ack_in));
        nxt_cmpf = hit_cmp | (cmpf_ff & ~((ctl_wr_in & wdata_in[`TTP_BIT_CMP_FLAG]) | cmp_ack_in));
        if (sw_reset_in) begin
            nxt_ctl    = `TTP_RST_CTL;
            nxt_ovf    = 1'b0;
            nxt_cmpf   = 1'b0;
            nxt_first  = 1'b0;
            nxt_reload = 1'b0;
        end
    end

    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctl_ff    <= `TTP_RST_CTL;
            cnt_ff    <= `TTP_RST_WORD;
            load_ff   <= `TTP_RST_WORD;
            cmpv_ff   <= `TTP_RST_WORD;
            ovf_ff    <= 1'b0;
            cmpf_ff   <= 1'b0;
            first_ff  <= 1'b0;
            reload_ff <= 1'b0;
            evt_ff    <= 1'b0;
        end else begin
            ctl_ff    <= nxt_ctl;
            cnt_ff    <= nxt_cnt;
            ovf_ff    <= nxt_ovf;
            cmpf_ff   <= nxt_cmpf;
            first_ff  <= nxt_first;
            reload_ff <= nxt_reload;
            evt_ff    <= hit_ovf | hit_cmp;
            if (load_wr_in) begin
                load_ff <= wdata_in;
            end
            if (cmp_wr_in) begin
                cmpv_ff <= wdata_in;
            end
        end
    end

    assign ctl_out     = ctl_ff | ({{(`TTP_DW-1){1'b0}}, ovf_ff} << `TTP_BIT_OVF_FLAG)
                                | ({{(`TTP_DW-1){1'b0}}, cmpf_ff} << `TTP_BIT_CMP_FLAG);
    assign count_out   = cnt_ff;
    assign compare_out = cmpv_ff;
    assign run_out     = run;
    assign pre_sel_out = ctl_ff[`TTP_BIT_PRE_SEL];
    assign ovf_out     = ovf_ff;
    assign cmp_out     = cmpf_ff;
    assign event_out   = evt_ff;
endmodule

// >>> tb/ttp_timer_properties.sv
// Port-level properties of the triple timer.
`timescale 1ns/100ps
module ttp_timer_chk (
    // Clock and reset
    input logic        clk_in,
    input logic        rst_b_in,
    input logic        sw_reset_in,
    // Watched ports
    input logic        core_stop_in,
    input logic        reg_rd_in,
    input logic        reg_wr_in,
    input logic [23:0] reg_rdata_out,
    input logic [2:0]  ovf_ack_in,
    input logic [2:0]  cmp_ack_in,
    input logic [2:0]  ovf_irq_out,
    input logic [2:0]  cmp_irq_out,
    input logic        wake_out,
    input logic [2:0]  dma_trig_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    sequence s_quiet;
        ovf_irq_out == 3'h0 && cmp_irq_out == 3'h0 ##1 !wake_out;
    endsequence
    property p_prio;
        (ovf_irq_out & cmp_irq_out) == 3'h0;
    endproperty
    a_prio: assert property (p_prio) else $error("compare irq beside overflow irq");
    property p_wake;
        wake_out == $past(|{ovf_irq_out, cmp_irq_out});
    endproperty
    a_wake: assert property (p_wake) else $error("wake does not follow irqs");
    property p_stop;
        core_stop_in ##1 core_stop_in |=> dma_trig_out == 3'h0;
    endproperty
    a_stop: assert property (p_stop) else $error("trigger while stopped");
    property p_oack;
        |ovf_ack_in |=> ##1 (($past(ovf_ack_in, 2) & ovf_irq_out & ~dma_trig_out) == 3'h0);
    endproperty
    a_oack: assert property (p_oack) else $error("overflow irq survives service");
    property p_cack;
        |cmp_ack_in |=> ##1 (($past(cmp_ack_in, 2) & cmp_irq_out & ~dma_trig_out) == 3'h0);
    endproperty
    a_cack: assert property (p_cack) else $error("compare irq survives service");
    property p_rise;
        $rose(ovf_irq_out[0]) |-> dma_trig_out[0] || $past(reg_wr_in, 2);
    endproperty
    a_rise: assert property (p_rise) else $error("overflow irq without trigger");
    property p_hold;
        !reg_rd_in |=> $stable(reg_rdata_out);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved without read");
    property p_swr;
        sw_reset_in |=> ##1 s_quiet;
    endproperty
    a_swr: assert property (p_swr) else $error("irqs left after soft reset");
endmodule
bind ttp_timer_top ttp_timer_chk chk_u (.clk_in, .rst_b_in, .sw_reset_in, .core_stop_in,
    .reg_rd_in, .reg_wr_in, .reg_rdata_out, .ovf_ack_in, .cmp_ack_in, .ovf_irq_out,
    .cmp_irq_out, .wake_out, .dma_trig_out);

// >>> tb/ttp_core_model.sv
// Core stand-in that services timer interrupts and takes DMA triggers.
`timescale 1ns/100ps
module ttp_core_model (
    // Clock and reset
    input  logic       clk_in,
    input  logic       rst_b_in,
    // Service enables and timer outputs
    input  logic [1:0] svc_in,
    input  logic [2:0] ovf_irq_in,
    input  logic [2:0] cmp_irq_in,
    input  logic [2:0] dma_trig_in,
    // Acks and trigger count
    output logic [2:0] ovf_ack_out,
    output logic [2:0] cmp_ack_out,
    output logic [7:0] dma_cnt_out
);
    // Acks are one-cycle pulses on the falling edge, away from the sampling edge.
    always @(negedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ovf_ack_out <= 3'h0;
            cmp_ack_out <= 3'h0;
        end else begin
            ovf_ack_out <= ovf_irq_in & ~ovf_ack_out & {3{svc_in[0]}};
            cmp_ack_out <= cmp_irq_in & ~cmp_ack_out & {3{svc_in[1]}};
        end
    end
    // Each channel 0 trigger is counted at once; triggers from channels 1 and 2 are not counted.
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in)
            dma_cnt_out <= 8'h00;
        else if (dma_trig_in[0])
            dma_cnt_out <= dma_cnt_out + 8'h01;
    end
endmodule

// >>> tb/ttp_timer_top_bench.sv
// Self-checking bench for the triple timer.
`timescale 1ns/100ps
module ttp_timer_top_bench;
    logic        clk_in = 1'h0;
    logic        rst_b_in = 1'h0;
    logic        sw_reset_in = 1'h0;
    logic        core_stop_in = 1'h0;
    logic [3:0]  reg_addr_in = 4'h0;
    logic        reg_wr_in = 1'h0;
    logic        reg_rd_in = 1'h0;
    logic [23:0] reg_wdata_in = 24'h0;
    logic [1:0]  svc = 2'h0;
    logic [23:0] reg_rdata_out, last;
    logic [2:0]  ovf_ack_in, cmp_ack_in, ovf_irq_out, cmp_irq_out, dma_trig_out;
    logic        wake_out;
    logic [7:0]  dma_cnt;
    int          errors = 0;
    int          samples_checked = 0;
    int          nchg;
    ttp_timer_top dut_u (.clk_in, .rst_b_in, .sw_reset_in, .core_stop_in, .reg_addr_in,
        .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .ovf_ack_in, .cmp_ack_in,
        .ovf_irq_out, .cmp_irq_out, .wake_out, .dma_trig_out);
    ttp_core_model model_u (.clk_in, .rst_b_in, .svc_in(svc), .ovf_irq_in(ovf_irq_out),
        .cmp_irq_in(cmp_irq_out), .dma_trig_in(dma_trig_out), .ovf_ack_out(ovf_ack_in),
        .cmp_ack_out(cmp_ack_in), .dma_cnt_out(dma_cnt));
    initial forever #50 clk_in = ~clk_in;
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [23:0] d);
        @(negedge clk_in);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'h1;
        @(negedge clk_in);
        reg_wr_in = 1'h0;
    endtask
    // Back-to-back reads; the expected value repeats with period per.
    task automatic rdseq(input logic [3:0] a, input logic [23:0] first, input int n, input int per);
        @(negedge clk_in);
        reg_addr_in = a;
        reg_rd_in = 1'h1;
        for (int i = 0; i < n; i++) begin
            @(negedge clk_in);
            chk(reg_rdata_out, first + 24'(i % per), "read");
        end
        reg_rd_in = 1'h0;
    endtask
    // Counts how often a register changes over n back-to-back reads.
    task automatic rdwatch(input logic [3:0] a, input int n);
        logic [23:0] prev;
        nchg = 0;
        @(negedge clk_in);
        reg_addr_in = a;
        reg_rd_in = 1'h1;
        for (int i = 0; i < n; i++) begin
            @(negedge clk_in);
            if (i > 0 && reg_rdata_out !== prev) nchg++;
            prev = reg_rdata_out;
        end
        reg_rd_in = 1'h0;
        last = prev;
    endtask
    task automatic t_regs;
        for (int k = 0; k < 3; k++) rdseq(4'(4 * k), 24'h0, 1, 1);
        wr(4'h3, 24'hABCDEF);
        wr(4'h2, 24'h123456);
        wr(4'h1, 24'h000055);
        rdseq(4'h3, 24'hABCDEF, 1, 1);
        rdseq(4'h2, 24'h0, 1, 1);
        rdseq(4'h1, 24'h0, 1, 1);
        rdseq(4'hE, 24'h0, 1, 1);
    endtask
    task automatic t_ovf;
        wr(4'h2, 24'hFFFFFD);
        wr(4'h3, 24'h000001);
        wr(4'h0, 24'h000007);
        rdseq(4'h1, 24'hFFFFFD, 6, 64);
        chk({21'h0, ovf_irq_out}, 24'h1, "ovf irq");
        chk({21'h0, cmp_irq_out}, 24'h0, "cmp irq");
        chk({16'h0, dma_cnt}, 24'h2, "triggers");
        chk({23'h0, wake_out}, 24'h1, "wake");
        wr(4'h0, 24'h000007);
        rdseq(4'h0, 24'h300007, 1, 1);
        svc <= 2'h1;
        for (int i = 0; i < 20 && ovf_irq_out[0] !== 1'h0; i++) @(negedge clk_in);
        if (ovf_irq_out[0] !== 1'h0) begin
            chk({21'h0, ovf_irq_out}, 24'h0, "ovf service timeout");
            wrap_up();
        end
        svc <= 2'h0;
        rdseq(4'h0, 24'h200007, 1, 1);
        chk({21'h0, cmp_irq_out}, 24'h1, "cmp irq");
        wr(4'h0, 24'h200007);
        rdseq(4'h0, 24'h000007, 1, 1);
    endtask
    task automatic t_reload;
        svc <= 2'h2;
        wr(4'h6, 24'h000005);
        wr(4'h7, 24'h000007);
        wr(4'h4, 24'h000205);
        rdseq(4'h5, 24'h000005, 7, 3);
        svc <= 2'h0;
    endtask
    task automatic t_stop;
        core_stop_in = 1'h1;
        rdwatch(4'h1, 6);
        chk(24'(nchg), 24'h0, "stopped");
        core_stop_in = 1'h0;
        rdwatch(4'h1, 6);
        chk(24'(nchg), 24'h5, "running");
        wr(4'h0, 24'h0);
        rdwatch(4'h1, 4);
        chk(24'(nchg), 24'h0, "disabled");
        wr(4'h0, 24'h000011);
        rdwatch(4'h1, 6);
        chk(last, 24'h0, "reserved mode");
        rdseq(4'h0, 24'h000011, 1, 1);
        wr(4'h0, 24'h0);
        wr(4'h4, 24'h0);
        core_stop_in = 1'h1;
        rdwatch(4'h5, 4);
        chk(24'(nchg), 24'h0, "idle stop");
        core_stop_in = 1'h0;
    endtask
    task automatic t_pre;
        wr(4'hA, 24'h000010);
        wr(4'hC, 24'h200002);
        wr(4'h8, 24'h008001);
        rdwatch(4'h9, 6);
        chk(last, 24'h0, "source halted");
        wr(4'h8, 24'h0);
        wr(4'hC, 24'h000002);
        wr(4'h8, 24'h008001);
        rdwatch(4'h9, 13);
        chk(24'(nchg), 24'h2, "prescaled ticks");
    endtask
    task automatic t_swr;
        sw_reset_in = 1'h1;
        @(negedge clk_in);
        sw_reset_in = 1'h0;
        for (int k = 0; k < 3; k++) rdseq(4'(4 * k), 24'h0, 1, 1);
    endtask
    task automatic wrap_up;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // A hang is cut short and counted as a failure.
    initial begin
        #1000000;
        chk(24'h1, 24'h0, "run timeout");
        wrap_up();
    end
    initial begin
        repeat (3) @(negedge clk_in);
        rst_b_in = 1'h1;
        t_regs();
        t_ovf();
        t_reload();
        t_stop();
        t_pre();
        t_swr();
        wrap_up();
    end
endmodule
